// file: hdl/sar_adc_map.svh
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// Register byte addresses
`define ADDR_CTRL        8'h00
`define ADDR_ACFG        8'h04
`define ADDR_TCFG        8'h08
`define ADDR_RES_HIGH    8'h0C
`define ADDR_RES_LOW     8'h10
`define ADDR_STATUS      8'h14

// Reset values and writable-bit masks
`define CTRL_RST         8'h00
`define ACFG_RST         8'h00
`define TCFG_RST         8'h00
`define CTRL_WMASK       8'h8F
`define ACFG_WMASK       8'h1F
`define TCFG_WMASK       8'hBF

// Field positions
`define CTRL_ON_BIT      0
`define CTRL_GO_BIT      1
`define CTRL_CHAN_LSB    2
`define CTRL_TRIG_BIT    7
`define ACFG_REF_BIT     4
`define TCFG_CLK_LSB     0
`define TCFG_ACQ_LSB     3
`define TCFG_JUST_BIT    7
`define STATUS_FLAG_BIT  0

// Timing
`define CLK_PERIOD_NS    4
`define TCY_NS           16
`define TCY_CYCLES       ((`TCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TADS        11
`define HOLDOFF_TADS     2

// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: hdl/sar_adc_pkg.sv
package sar_adc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DELAY,
		ST_ACQ,
		ST_CONV,
		ST_HOLDOFF
	} conv_state_t;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

	typedef struct packed {
		conv_state_t state;
		logic [7:0]  ctrl;
		logic [7:0]  acfg;
		logic [7:0]  tcfg;
		logic        flag;
		logic [9:0]  result;
		logic [9:0]  sar;
		logic [3:0]  bit_idx;
		logic [4:0]  tad_cnt;
		logic [5:0]  div_cnt;
		logic [2:0]  delay_cnt;
		logic        aw_held;
		logic [7:0]  awaddr;
		logic        w_held;
		logic [7:0]  wdata;
		logic        wlane;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
	} adc_state_t;

endpackage

// file: hdl/sar_adc_sequencer.sv
`timescale 1ns/1ps

`include "sar_adc_map.svh"

module sar_adc_sequencer
	import sar_adc_pkg::*;
(
	// System
	input  wire logic        clock,
	input  wire logic        reset,
	// Register bus
	input  wire axil_req_t   bus_req,
	output axil_rsp_t        bus_rsp,
	// Converter analog side
	input  wire logic        comp_in,
	input  wire logic        rc_tick,
	input  wire logic        sleep_mode,
	output logic [9:0]       dac_code,
	output logic             sample_connect,
	output logic [1:0]       channel_sel,
	output logic             pos_ref_select,
	output logic [3:0]       pin_digital_cfg,
	// Trigger and status
	input  wire logic        pwm_trigger,
	output logic             conv_done_flag,
	output logic             converting
);

	adc_state_t  st_q;
	adc_state_t  st_d;
	logic        tad_tick;
	logic        rc_sel;
	logic [5:0]  div_val;
	logic [4:0]  acq_len;
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        go_set;
	logic        go_abort;
	logic        conv_done;

	//----------------------------------------
	// Decoders
	//----------------------------------------

	function automatic logic [4:0] acq_decode(input logic [2:0] code);
		unique case (code)
			3'h0: acq_decode = 5'h00;
			3'h1: acq_decode = 5'h02;
			3'h2: acq_decode = 5'h04;
			3'h3: acq_decode = 5'h06;
			3'h4: acq_decode = 5'h08;
			3'h5: acq_decode = 5'h0C;
			3'h6: acq_decode = 5'h10;
			3'h7: acq_decode = 5'h14;
		endcase
	endfunction

	function automatic logic [5:0] div_decode(input logic [2:0] code);
		unique case (code)
			3'h0:    div_decode = 6'h02;
			3'h4:    div_decode = 6'h04;
			3'h1:    div_decode = 6'h08;
			3'h5:    div_decode = 6'h10;
			3'h2:    div_decode = 6'h20;
			3'h6:    div_decode = 6'h3F;
			default: div_decode = 6'h02;
		endcase
	endfunction

	// Value 64 does not fit; 6'h3F marks it and the compare below handles it
	assign rc_sel  = st_q.tcfg[`TCFG_CLK_LSB+1 -: 2] == 2'h3;
	assign div_val = div_decode(st_q.tcfg[`TCFG_CLK_LSB+2 -: 3]);
	assign acq_len = acq_decode(st_q.tcfg[`TCFG_ACQ_LSB+2 -: 3]);

	// bit period tick; system clock halted in sleep
	always_comb
	begin
		if (rc_sel)
			tad_tick = rc_tick && st_q.state != ST_IDLE && st_q.state != ST_DELAY;
		else if (sleep_mode || st_q.state == ST_IDLE || st_q.state == ST_DELAY)
			tad_tick = 1'b0;
		else if (div_val == 6'h3F)
			tad_tick = st_q.div_cnt == 6'h3F;
		else
			tad_tick = st_q.div_cnt == div_val - 6'h01;
	end

	//----------------------------------------
	// Bus handshakes
	//----------------------------------------

	assign aw_take = bus_req.awvalid && !st_q.aw_held && !st_q.bvalid;
	assign w_take  = bus_req.wvalid && !st_q.w_held && !st_q.bvalid;
	assign ar_take = bus_req.arvalid && !st_q.rvalid;

	//----------------------------------------
	// Next state
	//----------------------------------------

	always_comb
	begin
		logic [7:0] rd;
		logic       hit;
		logic       just;
		logic       wr_go;
		rd       = 8'h00;
		hit      = 1'b1;
		just     = st_q.tcfg[`TCFG_JUST_BIT];
		wr_go    = 1'b0;
		st_d     = st_q;
		go_set   = 1'b0;
		go_abort = 1'b0;
		conv_done = 1'b0;

		// Write channel capture, either order
		if (aw_take)
		begin
			st_d.aw_held = 1'b1;
			st_d.awaddr  = {bus_req.awaddr[7:2], 2'b00};
		end
		if (w_take)
		begin
			st_d.w_held = 1'b1;
			st_d.wdata  = bus_req.wdata[7:0];
			st_d.wlane  = bus_req.wstrb[0];
		end
		if (st_q.bvalid && bus_req.bready)
			st_d.bvalid = 1'b0;

		if (st_d.aw_held && st_d.w_held)
		begin
			st_d.aw_held = 1'b0;
			st_d.w_held  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = `RESP_OKAY;
			unique case (st_d.awaddr)
				`ADDR_CTRL:
					if (st_d.wlane)
					begin
						wr_go = 1'b1;
						st_d.ctrl = (st_d.wdata & `CTRL_WMASK) & ~(8'h01 << `CTRL_GO_BIT)
							| (st_q.ctrl & (8'h01 << `CTRL_GO_BIT));
					end
				`ADDR_ACFG:
					if (st_d.wlane)
						st_d.acfg = st_d.wdata & `ACFG_WMASK;
				`ADDR_TCFG:
					if (st_d.wlane)
						st_d.tcfg = st_d.wdata & `TCFG_WMASK;
				`ADDR_RES_HIGH:
					if (st_d.wlane && just)
						st_d.result[9:8] = st_d.wdata[1:0];
					else if (st_d.wlane)
						st_d.result[9:2] = st_d.wdata;
				`ADDR_RES_LOW:
					if (st_d.wlane && just)
						st_d.result[7:0] = st_d.wdata;
					else if (st_d.wlane)
						st_d.result[1:0] = st_d.wdata[7:6];
				`ADDR_STATUS:
					if (st_d.wlane)
						st_d.flag = st_d.wdata[`STATUS_FLAG_BIT];
				default:
					st_d.bresp = `RESP_SLVERR;
			endcase
		end

		// Read channel
		if (st_q.rvalid && bus_req.rready)
			st_d.rvalid = 1'b0;
		unique case ({bus_req.araddr[7:2], 2'b00})
			`ADDR_CTRL:     rd = st_q.ctrl;
			`ADDR_ACFG:     rd = st_q.acfg;
			`ADDR_TCFG:     rd = st_q.tcfg;
			`ADDR_RES_HIGH: rd = just ? {6'h00, st_q.result[9:8]} : st_q.result[9:2];
			`ADDR_RES_LOW:  rd = just ? st_q.result[7:0] : {st_q.result[1:0], 6'h00};
			`ADDR_STATUS:   rd = {7'h00, st_q.flag};
			default:        hit = 1'b0;
		endcase
		if (ar_take)
		begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = rd;
			st_d.rresp  = hit ? `RESP_OKAY : `RESP_SLVERR;
		end

		// Go control; same-write go with turn-on is ignored by using the old on bit
		// PWM trigger start
		go_set = st_q.ctrl[`CTRL_ON_BIT] && (
			(wr_go && st_d.wdata[`CTRL_GO_BIT])
			|| (pwm_trigger && st_q.ctrl[`CTRL_TRIG_BIT]));
		go_abort = wr_go && !st_d.wdata[`CTRL_GO_BIT] && st_q.ctrl[`CTRL_GO_BIT];
		if (go_set)
			st_d.ctrl[`CTRL_GO_BIT] = 1'b1;
		else if (go_abort)
			st_d.ctrl[`CTRL_GO_BIT] = 1'b0;

		// Divider restarts with every run
		if (st_q.state == ST_IDLE || st_q.state == ST_DELAY || tad_tick)
			st_d.div_cnt = 6'h00;
		else if (!sleep_mode)
			st_d.div_cnt = st_q.div_cnt + 6'h01;

		//----------------------------------------
		// Conversion sequencer
		//----------------------------------------
		unique case (st_q.state)
			ST_IDLE:
				if (st_q.ctrl[`CTRL_GO_BIT] && !go_abort)
				begin
					st_d.tad_cnt   = 5'h00;
					st_d.delay_cnt = 3'h0;
					if (rc_sel)
						st_d.state = ST_DELAY;
					else if (acq_len != 5'h00)
						st_d.state = ST_ACQ;
					else
						st_d.state = ST_CONV;
				end
			ST_DELAY:
				if (st_q.delay_cnt == 3'(`TCY_CYCLES - 1))
					st_d.state = (acq_len != 5'h00) ? ST_ACQ : ST_CONV;
				else
					st_d.delay_cnt = st_q.delay_cnt + 3'h1;
			ST_ACQ:
				if (tad_tick)
				begin
					st_d.tad_cnt = st_q.tad_cnt + 5'h01;
					if (st_q.tad_cnt + 5'h01 >= acq_len)
					begin
						st_d.state   = ST_CONV;
						st_d.tad_cnt = 5'h00;
					end
				end
			ST_CONV:
				if (tad_tick)
				begin
					st_d.tad_cnt = st_q.tad_cnt + 5'h01;
					if (st_q.tad_cnt == 5'(`CONV_TADS - 1))
					begin
						conv_done     = 1'b1;
						st_d.result   = st_q.sar;
						st_d.flag     = 1'b1;
						st_d.ctrl[`CTRL_GO_BIT] = go_set;
						st_d.state    = ST_HOLDOFF;
						st_d.tad_cnt  = 5'h00;
					end
					else
					begin
						st_d.sar[st_q.bit_idx] = comp_in;
						if (st_q.bit_idx != 4'h0)
						begin
							st_d.sar[st_q.bit_idx - 4'h1] = 1'b1;
							st_d.bit_idx = st_q.bit_idx - 4'h1;
						end
					end
				end
			ST_HOLDOFF:
				if (tad_tick)
				begin
					st_d.tad_cnt = st_q.tad_cnt + 5'h01;
					if (st_q.tad_cnt == 5'(`HOLDOFF_TADS - 1))
						st_d.state = ST_IDLE;
				end
		endcase

		// First trial code loaded on entry to conversion
		if (st_d.state == ST_CONV && st_q.state != ST_CONV)
		begin
			st_d.sar     = 10'h200;
			st_d.bit_idx = 4'h9;
		end

		if (go_abort && st_q.state != ST_IDLE && st_q.state != ST_HOLDOFF)
		begin
			st_d.state   = ST_HOLDOFF;
			st_d.tad_cnt = 5'h00;
		end

		if (!st_d.ctrl[`CTRL_ON_BIT])
		begin
			st_d.state = ST_IDLE;
			st_d.ctrl[`CTRL_GO_BIT] = 1'b0;
		end

		// reset aborts and clears; result kept
		if (reset)
		begin
			st_d        = '0;
			st_d.state  = ST_IDLE;
			st_d.ctrl   = `CTRL_RST;
			st_d.acfg   = `ACFG_RST;
			st_d.tcfg   = `TCFG_RST;
			st_d.result = st_q.result;
		end
	end

	always_ff @(posedge clock)
	begin
		st_q <= st_d;
	end

	//----------------------------------------
	// Outputs
	//----------------------------------------

	assign bus_rsp.awready = !st_q.aw_held && !st_q.bvalid;
	assign bus_rsp.wready  = !st_q.w_held && !st_q.bvalid;
	assign bus_rsp.bvalid  = st_q.bvalid;
	assign bus_rsp.bresp   = st_q.bresp;
	assign bus_rsp.arready = !st_q.rvalid;
	assign bus_rsp.rvalid  = st_q.rvalid;
	assign bus_rsp.rdata   = {24'h000000, st_q.rdata};
	assign bus_rsp.rresp   = st_q.rresp;

	// capacitor held off from conversion start to holdoff end
	assign sample_connect  = st_q.state == ST_IDLE || st_q.state == ST_DELAY
		|| st_q.state == ST_ACQ;
	assign dac_code        = st_q.sar;
	assign channel_sel     = st_q.ctrl[`CTRL_CHAN_LSB+1 -: 2];
	assign pos_ref_select  = st_q.acfg[`ACFG_REF_BIT];
	assign pin_digital_cfg = st_q.acfg[3:0];
	assign conv_done_flag  = st_q.flag;
	assign converting      = st_q.ctrl[`CTRL_GO_BIT];

	//----------------------------------------
	// Checks
	//----------------------------------------

	logic [5:0] ticks_in_state;
	always_ff @(posedge clock)
	begin
		if (reset || st_q.state != st_d.state)
			ticks_in_state <= 6'h00;
		else if (tad_tick)
			ticks_in_state <= ticks_in_state + 6'h01;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence conv_ends;
		st_q.state == ST_CONV && tad_tick && st_d.state == ST_HOLDOFF && !go_abort;
	endsequence

	sequence enter_delay;
		st_q.state == ST_IDLE && st_d.state != ST_IDLE && rc_sel;
	endsequence

	a_done_sets_flag: assert property (conv_ends |=> st_q.flag
		&& st_q.result == $past(st_q.sar) && converting == $past(go_set))
		else $error("completion did not load result and flag");
	a_done_pulse_flag: assert property (conv_done |=> conv_done_flag)
		else $error("completion did not raise the done flag");
	a_conv_length: assert property (conv_ends |-> ticks_in_state == 6'(`CONV_TADS - 1))
		else $error("conversion length wrong");
	a_holdoff_length: assert property (st_q.state == ST_HOLDOFF
		&& st_d.state == ST_IDLE && st_q.ctrl[`CTRL_ON_BIT]
		|-> ticks_in_state == 6'(`HOLDOFF_TADS - 1))
		else $error("holdoff shorter than two periods");
	a_acq_length: assert property (st_q.state == ST_ACQ
		&& st_d.state == ST_CONV && !go_abort
		|-> ticks_in_state + 6'h01 == 6'(acq_len))
		else $error("acquisition length wrong");
	// Start delay spans one instruction cycle unless the run is dropped
	a_rc_delay: assert property (enter_delay
		|=> (st_q.state == ST_DELAY || !converting)[*4] ##1 st_q.state != ST_DELAY)
		else $error("RC start delay missing");
	a_cap_open: assert property ($rose(st_q.state == ST_CONV)
		|-> !sample_connect && $past(sample_connect))
		else $error("capacitor not disconnected at start");
	a_abort_keeps: assert property (go_abort && st_q.state == ST_CONV
		|=> st_q.result == $past(st_q.result)
		&& (st_q.state == ST_HOLDOFF || !st_q.ctrl[`CTRL_ON_BIT]))
		else $error("abort changed result");
	a_trigger_go: assert property (pwm_trigger && st_q.ctrl[`CTRL_TRIG_BIT]
		&& st_q.ctrl[`CTRL_ON_BIT] && !go_abort
		|=> converting || !st_q.ctrl[`CTRL_ON_BIT])
		else $error("trigger did not set go");
	a_reset_off: assert property (disable iff (1'b0) $past(reset)
		|-> st_q.state == ST_IDLE && st_q.ctrl == `CTRL_RST
		&& st_q.acfg == `ACFG_RST && st_q.tcfg == `TCFG_RST)
		else $error("reset did not clear converter");
	a_sleep_clock: assert property (sleep_mode && !rc_sel |-> !tad_tick)
		else $error("divided clock ran in sleep");
	a_ref_route: assert property (pos_ref_select == st_q.acfg[`ACFG_REF_BIT]
		&& pin_digital_cfg == st_q.acfg[3:0])
		else $error("reference or pin config not routed");

endmodule

// file: testbench/adc_analog_model.sv
`timescale 1ns/1ps

module adc_analog_model
#(
	parameter int RC_PER = 8
)
(
	// System
	input  wire logic        clock,
	// Analog sources and selection
	input  wire logic [39:0] levels,
	input  wire logic [1:0]  channel_sel,
	input  wire logic        sample_connect,
	input  wire logic [9:0]  dac_code,
	// Trigger request from the bench
	input  wire logic        fire,
	// Towards the converter
	output logic             comp_in,
	output logic             rc_tick,
	output logic             pwm_trigger
);
	logic [9:0] held_q;
	int         rc_cnt_q = 0;

	// --------------------------------
	// Sample and hold, comparator, RC tick and trigger
	// --------------------------------
	// Cap follows the pin only while connected; a late disconnect shows as a wrong code
	always @(posedge clock)
		if (sample_connect)
			held_q <= levels[channel_sel * 10 +: 10];

	assign comp_in = (held_q >= dac_code);

	always @(posedge clock)
	begin
		rc_cnt_q <= (rc_cnt_q == RC_PER - 1) ? 0 : rc_cnt_q + 1;
		rc_tick  <= (rc_cnt_q == RC_PER - 1);
	end

	always @(posedge clock)
		pwm_trigger <= fire;
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps

`include "sar_adc_map.svh"

module tb
	import sar_adc_pkg::*;
;
	localparam int         rc_per = 8;
	localparam logic [2:0] clk_code [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	localparam int         div_of [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
	localparam int         acq_of [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	localparam logic [7:0] reg_addr [4] = '{`ADDR_CTRL, `ADDR_ACFG, `ADDR_TCFG, `ADDR_STATUS};

	logic        clock;
	logic        reset;
	axil_req_t   req;
	axil_rsp_t   rsp;
	logic        comp_in, rc_tick, sleep_mode, pwm_trigger, fire;
	logic        sample_connect, pos_ref_select, conv_done_flag, converting;
	logic [9:0]  dac_code;
	logic [1:0]  channel_sel;
	logic [3:0]  pin_digital_cfg;
	logic [39:0] levels;
	logic [31:0] rdv;
	logic [1:0]  rsv;
	int          n_fail;
	int          compares;

	sar_adc_sequencer DUT (.clock(clock), .reset(reset), .bus_req(req), .bus_rsp(rsp),
		.comp_in(comp_in), .rc_tick(rc_tick), .sleep_mode(sleep_mode), .dac_code(dac_code),
		.sample_connect(sample_connect), .channel_sel(channel_sel),
		.pos_ref_select(pos_ref_select), .pin_digital_cfg(pin_digital_cfg),
		.pwm_trigger(pwm_trigger), .conv_done_flag(conv_done_flag), .converting(converting));

	adc_analog_model #(.RC_PER(rc_per)) far (.clock(clock), .levels(levels),
		.channel_sel(channel_sel), .sample_connect(sample_connect), .dac_code(dac_code),
		.fire(fire), .comp_in(comp_in), .rc_tick(rc_tick), .pwm_trigger(pwm_trigger));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// --------------------------------
	// Bus and checking helpers
	// --------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Ready is looked at mid-cycle, where it already shows what the next edge samples
	task automatic bus(input bit is_wr, input logic [7:0] a, input logic [31:0] d);
		bit ad;
		bit wd;
		bit ta;
		bit tw;
		int n;
		ad = 1'b0;
		wd = !is_wr;
		@(posedge clock);
		if (is_wr)
			req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF,
				bready: 1'b1, default: '0};
		else
			req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
		for (n = 0; n < 100 && !(ad && wd); n++)
		begin
			@(negedge clock);
			ta = !ad && (is_wr ? rsp.awready : rsp.arready);
			tw = !wd && rsp.wready;
			@(posedge clock);
			if (ta)
			begin
				ad = 1'b1;
				req.awvalid <= 1'b0;
				req.arvalid <= 1'b0;
			end
			if (tw)
			begin
				wd = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		@(negedge clock);
		for (n = 0; n < 100 && !(is_wr ? rsp.bvalid : rsp.rvalid); n++)
			@(negedge clock);
		rdv = rsp.rdata;
		rsv = is_wr ? rsp.bresp : rsp.rresp;
		check(is_wr ? rsp.bvalid : rsp.rvalid, 1'b1, "bus answer"); // access
		@(posedge clock);
		req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		check(rsv, `RESP_OKAY, "write response");
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wait_idle;
		for (int n = 0; n < 500 && sample_connect !== 1'b1; n++)
			@(negedge clock);
		check(sample_connect, 1'b1, "idle reached"); // idle
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_defaults;
		@(negedge clock);
		check(converting, 1'b0, "busy after reset"); // off
		check(sample_connect, 1'b1, "cap after reset"); // idle
		check(conv_done_flag, 1'b0, "flag after reset"); // cleared
		check({pos_ref_select, pin_digital_cfg}, 5'h00, "pins after reset"); // cleared
		for (int k = 0; k < 4; k++)
		begin
			rd(reg_addr[k]);
			check(rdv, 32'h0, "reset value"); // defaults
		end
		bus(1'b1, 8'h18, 32'hFF);
		check(rsv, `RESP_SLVERR, "unmapped write");
		bus(1'b0, 8'h18, 32'h0);
		check(rsv, `RESP_SLVERR, "unmapped read");
		check(rdv, 32'h0, "unmapped data");
	endtask

	task automatic t_cfg;
		logic [7:0] v [2];
		v = '{8'h1A, 8'h05};
		for (int k = 0; k < 2; k++)
		begin
			wr(`ADDR_ACFG, {24'h0, v[k]});
			@(negedge clock);
			check(pos_ref_select, v[k][4], "ref select"); // reference
			check(pin_digital_cfg, v[k][3:0], "pin config"); // pin mode
			rd(`ADDR_ACFG);
			check(rdv, v[k], "config readback"); // readback
		end
	endtask

	task automatic t_conv(input int i);
		logic [2:0]  ck;
		logic        j;
		logic [1:0]  ch;
		logic [15:0] e;
		int          per;
		int          n;
		ck = clk_code[i];
		j = i[2] ^ i[0];
		ch = i[1:0];
		per = (ck[1:0] == 2'b11) ? rc_per : div_of[ck];
		e = j ? {6'h00, levels[ch * 10 +: 10]} : {levels[ch * 10 +: 10], 6'h00};
		wr(`ADDR_TCFG, {24'h0, j, 1'b0, i[2:0], ck});
		// channel set and sampled before go
		wr(`ADDR_CTRL, {28'h0, ch, 2'b01});
		wr(`ADDR_STATUS, 32'h0);
		wr(`ADDR_CTRL, {28'h0, ch, 2'b11});
		@(negedge clock);
		check(converting, 1'b1, "busy"); // busy
		check(channel_sel, ch, "channel"); // routing
		for (n = 0; n < 3000 && converting === 1'b1; n++)
			@(negedge clock);
		check(n >= (acq_of[i] + 10) * per + 2 && n <= (acq_of[i] + 12) * per + 8, 1'b1,
			"run length"); // timing
		for (n = 0; n < 500 && sample_connect !== 1'b1; n++)
			@(negedge clock);
		check(n >= 2 * per - 2 && n <= 2 * per + 2, 1'b1, "holdoff"); // wait
		check(conv_done_flag, 1'b1, "done flag"); // flag
		rd(`ADDR_RES_HIGH);
		check(rdv, e[15:8], "result high"); // result
		rd(`ADDR_RES_LOW);
		check(rdv, e[7:0], "result low"); // result
		rd(`ADDR_CTRL);
		check(rdv, {28'h0, ch, 2'b01}, "go cleared"); // go
	endtask

	task automatic t_rc_sleep;
		int n;
		wr(`ADDR_TCFG, 32'h03);
		wr(`ADDR_CTRL, 32'h09);
		wr(`ADDR_STATUS, 32'h0);
		sleep_mode <= 1'b1;
		wr(`ADDR_CTRL, 32'h0B);
		@(negedge clock);
		for (n = 0; n < 50 && sample_connect === 1'b1; n++)
			@(negedge clock);
		check(n >= 3 && n <= 6 + rc_per, 1'b1, "rc start delay"); // delay
		for (n = 0; n < 2000 && converting === 1'b1; n++)
			@(negedge clock);
		check(conv_done_flag, 1'b1, "done in sleep"); // sleep
		rd(`ADDR_RES_HIGH);
		check(rdv, levels[29:22], "sleep result"); // result
		wait_idle();
		wr(`ADDR_TCFG, 32'h02);
		wr(`ADDR_STATUS, 32'h0);
		wr(`ADDR_CTRL, 32'h0B);
		repeat (600) @(negedge clock);
		check(converting, 1'b1, "halted in sleep"); // halt
		wr(`ADDR_CTRL, 32'h09);
		sleep_mode <= 1'b0;
		@(negedge clock);
		check(converting, 1'b0, "abort"); // abort
		check(conv_done_flag, 1'b0, "no flag on abort"); // no flag
		rd(`ADDR_RES_HIGH);
		check(rdv, levels[29:22], "kept result"); // kept
	endtask

	task automatic t_trig;
		int n;
		wait_idle();
		wr(`ADDR_TCFG, 32'h00);
		wr(`ADDR_STATUS, 32'h0);
		wr(`ADDR_CTRL, 32'h01);
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		repeat (10) @(negedge clock);
		check(converting, 1'b0, "trigger masked"); // disabled
		check(conv_done_flag, 1'b0, "flag cleared"); // clear
		wr(`ADDR_CTRL, 32'h81);
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		for (n = 0; n < 20 && converting !== 1'b1; n++)
			@(negedge clock);
		check(converting, 1'b1, "trigger start"); // trigger
		for (n = 0; n < 500 && converting === 1'b1; n++)
			@(negedge clock);
		check(conv_done_flag, 1'b1, "trigger done"); // flag
		rd(`ADDR_RES_HIGH);
		check(rdv, levels[9:2], "trigger result"); // result
	endtask

	task automatic t_reset_mid;
		wait_idle();
		wr(`ADDR_TCFG, 32'h06);
		wr(`ADDR_CTRL, 32'h01);
		wr(`ADDR_CTRL, 32'h03);
		repeat (100) @(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		t_defaults();
		rd(`ADDR_RES_HIGH);
		check(rdv, levels[9:2], "result kept over reset"); // kept
		wr(`ADDR_RES_HIGH, 32'hA5);
		wr(`ADDR_RES_LOW, 32'hFF);
		rd(`ADDR_RES_HIGH);
		check(rdv, 32'hA5, "written result high"); // written
		rd(`ADDR_RES_LOW);
		check(rdv, 32'hC0, "written result low"); // low zero
		wr(`ADDR_CTRL, 32'h03);
		repeat (4) @(negedge clock);
		check(converting, 1'b0, "go with turn-on"); // ignored
	endtask

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_fail++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial
	begin
		reset = 1'b1;
		req = '0;
		sleep_mode = 1'b0;
		fire = 1'b0;
		levels = {10'h15A, 10'h2C3, 10'h000, 10'h3FF};
		n_fail = 0;
		compares = 0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		t_defaults();
		t_cfg();
		for (int i = 0; i < 8; i++)
			t_conv(i);
		t_rc_sleep();
		t_trig();
		t_reset_mid();
		wrap_up();
	end
endmodule
